// file: design/vtc_defs.svh
/*
 holds the select codes, timing word field positions, reset values and fixed counts of the video timing controller.
 assumes it is included by bare name from every design file that needs a constant.
*/
// Operation
// - select 1010 with strobe resets timing chain
// - reset holds counters at even-field top
// - start releases timing chain one line later
// - select 0111 self loads until start command
// - held 1111 self loads after strobe falls
// - removing 1111 ends load, timing one line later
// - scroll 1011 advances first displayed row, wrapping
// - select 0000-0110 stores bus into timing word
// - cursor line/character addresses readable and loadable
// - character slots per line equal N plus one
// - row length code selects 20 to 132
// - sync delay field sets front porch width
// - sync width field sets pulse width
// - skew delays sync/blank and cursor separately
// - interlace: 2X+513 scans, sync every half frame
// - non-interlace: 2X+256 scans per frame
// - vertical sync three lines; data starts N lines later
// - N+1 data rows; last-row field wraps address
// - scans per row N+1, interlace variant N+2
// - self load addresses prom by row select
`ifndef VTC_DEFS_SVH
`define VTC_DEFS_SVH

`define VTC_CMD_CPU_LOAD   4'h7
`define VTC_CMD_RD_ROW     4'h8
`define VTC_CMD_RD_COL     4'h9
`define VTC_CMD_RESET      4'ha
`define VTC_CMD_SCROLL     4'hb
`define VTC_CMD_LD_COL     4'hc
`define VTC_CMD_LD_ROW     4'hd
`define VTC_CMD_START      4'he
`define VTC_CMD_PIN_LOAD   4'hf

`define VTC_WORDS          7
`define VTC_LAST_WORD      4'h6

`define VTC_ILACE_BIT      7
`define VTC_HSW_MSB        6
`define VTC_HSW_LSB        3
`define VTC_HSD_MSB        2
`define VTC_HSD_LSB        0
`define VTC_SPR_MSB        6
`define VTC_SPR_LSB        3
`define VTC_CPR_MSB        2
`define VTC_CPR_LSB        0
`define VTC_SKEW_MSB       7
`define VTC_SKEW_LSB       6
`define VTC_ROWS_MSB       5
`define VTC_ROWS_LSB       0

`define VTC_WORD_RESET     8'h00
`define VTC_CURSOR_RESET   8'h00

`define VTC_ILACE_LAST     10'h200
`define VTC_PROG_LAST      10'h0ff
`define VTC_VSYNC_LINES    2'h3

`define VTC_CPR_0          8'h14
`define VTC_CPR_1          8'h20
`define VTC_CPR_2          8'h28
`define VTC_CPR_3          8'h40
`define VTC_CPR_4          8'h48
`define VTC_CPR_5          8'h50
`define VTC_CPR_6          8'h60
`define VTC_CPR_7          8'h84

`endif

// file: design/vtc_pkg.sv
/*
 holds the types of the video timing controller.
 assumes nothing beyond a compiler that reads packages first.
*/
package vtc_pkg;
    typedef enum logic [4:0] {
        st_run      = 5'h01,
        st_held     = 5'h02,
        st_cpu_load = 5'h04,
        st_pin_load = 5'h08,
        st_release  = 5'h10
    } vtc_state_type;
endpackage

// file: design/vtc_skew_line.sv
/*
 holds a two-stage delay line stepped by the character tick, with a registered tap select of 0, 1 or 2 stages.
 assumes tick is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/1ps
module vtc_skew_line #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         tick,
    input  wire logic [1:0]   sel,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_stage2;
    logic [W-1:0] next_q;

    always_comb begin
        next_stage1 = tick ? d : stage1;
        next_stage2 = tick ? stage1 : stage2;
        unique case (sel)
            2'h0:    next_q = d;
            2'h1:    next_q = stage1;
            default: next_q = stage2;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            q      <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
            q      <= next_q;
        end
    end
endmodule // vtc_skew_line

// file: design/vtc_timing.sv
/*
 holds the command decode, timing words, cursor registers, self load and raster timing chain.
 assumes char_clk, load_strobe, select lines and bus input are synchronous to clk; the strobe is active high.
*/
`timescale 1ns/1ps
`include "vtc_defs.svh"
module vtc_timing #(
    parameter bit ILACE_ROW_PLUS_TWO = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       char_clk,
    input  wire logic       load_strobe,
    input  wire logic [3:0] command_select_lines,
    input  wire logic [7:0] parallel_bus_lines_in,
    output logic      [7:0] parallel_bus_lines_out,
    output logic            parallel_bus_lines_oe_n,
    output logic      [7:0] char_count,
    output logic      [3:0] row_select,
    output logic      [5:0] data_row,
    output logic            field,
    output logic            hsync,
    output logic            vsync,
    output logic            blank,
    output logic            cursor_video
);
    vtc_pkg::vtc_state_type state;
    vtc_pkg::vtc_state_type next_state;

    logic [7:0] timing_word      [`VTC_WORDS];
    logic [7:0] next_timing_word [`VTC_WORDS];
    logic [7:0] cursor_row_position;
    logic [7:0] cursor_column_position;
    logic [7:0] next_cursor_row_position;
    logic [7:0] next_cursor_column_position;
    logic [5:0] first_row;
    logic [5:0] next_first_row;
    logic [7:0] next_bus_out;
    logic       next_bus_oe_n;

    logic       char_prev;
    logic       strobe_prev;
    logic [7:0] hcount;
    logic [9:0] vline;
    logic [3:0] scan;
    logic [5:0] drow;
    logic [5:0] rows_left;
    logic       in_data;
    logic [7:0] since_vs;
    logic [1:0] vs_left;
    logic [7:0] vs_pos;
    logic       fld;
    logic [7:0] next_hcount;
    logic [9:0] next_vline;
    logic [3:0] next_scan;
    logic [5:0] next_drow;
    logic [5:0] next_rows_left;
    logic       next_in_data;
    logic [7:0] next_since_vs;
    logic [1:0] next_vs_left;
    logic [7:0] next_vs_pos;
    logic       next_fld;

    logic       tick;
    logic       strobe_rise;
    logic       strobe_fall;
    logic       hwrap;
    logic       ilace;
    logic       loading;
    logic [7:0] active;
    logic [8:0] hs_begin;
    logic [8:0] hs_end;
    logic [9:0] last_line;
    logic [3:0] spr_last;
    logic [5:0] last_row;
    logic       vs_start;
    logic       hsync_raw;
    logic       blank_raw;
    logic       cursor_raw;
    logic [1:0] skew;
    logic [1:0] sb_sel;
    logic [1:0] cur_sel;

    function automatic logic [7:0] active_chars(input logic [2:0] code);
        unique case (code)
            3'h0: active_chars = `VTC_CPR_0;
            3'h1: active_chars = `VTC_CPR_1;
            3'h2: active_chars = `VTC_CPR_2;
            3'h3: active_chars = `VTC_CPR_3;
            3'h4: active_chars = `VTC_CPR_4;
            3'h5: active_chars = `VTC_CPR_5;
            3'h6: active_chars = `VTC_CPR_6;
            3'h7: active_chars = `VTC_CPR_7;
        endcase
    endfunction

    function automatic logic [5:0] wrap_row(input logic [5:0] r, input logic [5:0] last);
        wrap_row = (r == last) ? 6'h00 : r + 6'h01;
    endfunction

    // strobe is one pin for reads and writes; the select code alone gives direction
    assign tick        = char_clk & ~char_prev;
    assign strobe_rise = load_strobe & ~strobe_prev;
    assign strobe_fall = ~load_strobe & strobe_prev;
    assign hwrap       = tick && (hcount == timing_word[0]);
    assign ilace       = timing_word[1][`VTC_ILACE_BIT];
    assign loading     = (state == vtc_pkg::st_cpu_load) || (state == vtc_pkg::st_pin_load);
    assign active      = active_chars(timing_word[2][`VTC_CPR_MSB:`VTC_CPR_LSB]);
    // zero delay or width is disallowed; such values just give a shifted or empty pulse
    assign hs_begin    = {1'b0, active} + {6'h00, timing_word[1][`VTC_HSD_MSB:`VTC_HSD_LSB]};
    assign hs_end      = hs_begin + {5'h00, timing_word[1][`VTC_HSW_MSB:`VTC_HSW_LSB]};
    assign last_line   = {1'b0, timing_word[3], 1'b0} + (ilace ? `VTC_ILACE_LAST : `VTC_PROG_LAST);
    assign spr_last    = (ilace && ILACE_ROW_PLUS_TWO) ? timing_word[2][`VTC_SPR_MSB:`VTC_SPR_LSB] + 4'h1
                                                       : timing_word[2][`VTC_SPR_MSB:`VTC_SPR_LSB];
    assign last_row    = timing_word[6][`VTC_ROWS_MSB:`VTC_ROWS_LSB];
    assign skew        = timing_word[5][`VTC_SKEW_MSB:`VTC_SKEW_LSB];
    assign sb_sel      = (skew == 2'h3) ? 2'h2 : skew;
    assign cur_sel     = (skew == 2'h3) ? 2'h2 : {1'b0, skew[1]};
    // second field sync lands mid-line so the two fields interleave
    assign vs_start    = (state == vtc_pkg::st_run) && tick && (((hcount == 8'h00) && (vline == 10'h000)) ||
                         (ilace && (vline == {2'h1, timing_word[3]}) && (hcount == {1'b0, timing_word[0][7:1]})));
    assign hsync_raw   = (state == vtc_pkg::st_run) && ({1'b0, hcount} >= hs_begin) && ({1'b0, hcount} < hs_end);
    assign blank_raw   = !in_data || (hcount >= active);
    assign cursor_raw  = in_data && (hcount < active) && ({2'h0, drow} == cursor_row_position)
                         && (hcount == cursor_column_position);

    always_comb begin
        next_state = state;
        unique case (state)
            vtc_pkg::st_run, vtc_pkg::st_held: begin
                if (strobe_rise && command_select_lines == `VTC_CMD_CPU_LOAD) next_state = vtc_pkg::st_cpu_load;
                if (strobe_rise && command_select_lines == `VTC_CMD_START && state == vtc_pkg::st_held)
                    next_state = vtc_pkg::st_release;
            end
            vtc_pkg::st_cpu_load: begin
                if (strobe_rise && command_select_lines == `VTC_CMD_START) next_state = vtc_pkg::st_release;
            end
            vtc_pkg::st_pin_load: begin
                if (command_select_lines != `VTC_CMD_PIN_LOAD) next_state = vtc_pkg::st_release;
            end
            vtc_pkg::st_release: begin
                if (hwrap) next_state = vtc_pkg::st_run;
            end
        endcase
        if (strobe_fall && command_select_lines == `VTC_CMD_PIN_LOAD) next_state = vtc_pkg::st_pin_load;
        if (strobe_rise && command_select_lines == `VTC_CMD_RESET) next_state = vtc_pkg::st_held;
    end

    always_comb begin
        next_timing_word            = timing_word;
        next_cursor_row_position    = cursor_row_position;
        next_cursor_column_position = cursor_column_position;
        next_first_row              = first_row;
        if (strobe_rise && !command_select_lines[3] && command_select_lines != `VTC_CMD_CPU_LOAD)
            next_timing_word[command_select_lines[2:0]] = parallel_bus_lines_in;
        // prom word k is addressed by row select k; captured at the end of that line
        if (loading && hwrap && scan <= `VTC_LAST_WORD) next_timing_word[scan[2:0]] = parallel_bus_lines_in;
        if (strobe_rise && command_select_lines == `VTC_CMD_LD_ROW) next_cursor_row_position = parallel_bus_lines_in;
        if (strobe_rise && command_select_lines == `VTC_CMD_LD_COL)
            next_cursor_column_position = parallel_bus_lines_in;
        if (strobe_rise && command_select_lines == `VTC_CMD_SCROLL) next_first_row = wrap_row(first_row, last_row);
        next_bus_out  = (command_select_lines == `VTC_CMD_RD_ROW) ? cursor_row_position : cursor_column_position;
        next_bus_oe_n = !(load_strobe && (command_select_lines == `VTC_CMD_RD_ROW ||
                                          command_select_lines == `VTC_CMD_RD_COL));
    end

    always_comb begin
        next_hcount    = hcount;
        next_vline     = vline;
        next_scan      = scan;
        next_drow      = drow;
        next_rows_left = rows_left;
        next_in_data   = in_data;
        next_since_vs  = since_vs;
        next_vs_left   = vs_left;
        next_vs_pos    = vs_pos;
        next_fld       = fld;
        if (state == vtc_pkg::st_held) begin
            next_hcount  = 8'h00;
            next_vline   = 10'h000;
            next_scan    = 4'h0;
            next_drow    = 6'h00;
            next_in_data = 1'b0;
            next_vs_left = 2'h0;
            next_fld     = 1'b0;
        end else if (tick) begin
            next_hcount = hwrap ? 8'h00 : hcount + 8'h01;
            if (loading && hwrap) next_scan = scan + 4'h1;
            if (state == vtc_pkg::st_run) begin
                if (vs_left != 2'h0 && hcount == vs_pos) next_vs_left = vs_left - 2'h1;
                if (hwrap) begin
                    next_vline    = (vline == last_line) ? 10'h000 : vline + 10'h001;
                    next_since_vs = (since_vs == 8'hff) ? since_vs : since_vs + 8'h01;
                    if (in_data) begin
                        if (scan == spr_last) begin
                            next_scan = 4'h0;
                            if (rows_left == 6'h00) next_in_data = 1'b0;
                            else begin
                                next_rows_left = rows_left - 6'h01;
                                next_drow      = wrap_row(drow, last_row);
                            end
                        end else next_scan = scan + 4'h1;
                    end
                    if (since_vs + 8'h01 == timing_word[4] && timing_word[4] != 8'h00) begin
                        next_in_data   = 1'b1;
                        next_scan      = 4'h0;
                        next_drow      = first_row;
                        next_rows_left = timing_word[5][`VTC_ROWS_MSB:`VTC_ROWS_LSB];
                    end
                end
                if (vs_start) begin
                    next_vs_left  = `VTC_VSYNC_LINES;
                    next_vs_pos   = hcount;
                    next_since_vs = 8'h00;
                    next_fld      = ilace ? ~fld : 1'b0;
                    if (timing_word[4] == 8'h00) begin
                        next_in_data   = 1'b1;
                        next_scan      = 4'h0;
                        next_drow      = first_row;
                        next_rows_left = timing_word[5][`VTC_ROWS_MSB:`VTC_ROWS_LSB];
                    end
                end
            end else begin
                // a stopped chain must not leave vertical sync stuck high
                next_vs_left = 2'h0;
                if (!loading) begin
                    next_vline   = 10'h000;
                    next_scan    = 4'h0;
                    next_in_data = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= vtc_pkg::st_held;
            for (int i = 0; i < `VTC_WORDS; i++) begin
                timing_word[i] <= `VTC_WORD_RESET;
            end
            cursor_row_position     <= `VTC_CURSOR_RESET;
            cursor_column_position  <= `VTC_CURSOR_RESET;
            first_row               <= 6'h00;
            parallel_bus_lines_out  <= 8'h00;
            parallel_bus_lines_oe_n <= 1'b1;
        end else begin
            state                   <= next_state;
            timing_word             <= next_timing_word;
            cursor_row_position     <= next_cursor_row_position;
            cursor_column_position  <= next_cursor_column_position;
            first_row               <= next_first_row;
            parallel_bus_lines_out  <= next_bus_out;
            parallel_bus_lines_oe_n <= next_bus_oe_n;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            char_prev   <= 1'b0;
            strobe_prev <= 1'b0;
            hcount      <= 8'h00;
            vline       <= 10'h000;
            scan        <= 4'h0;
            drow        <= 6'h00;
            rows_left   <= 6'h00;
            in_data     <= 1'b0;
            since_vs    <= 8'h00;
            vs_left     <= 2'h0;
            vs_pos      <= 8'h00;
            fld         <= 1'b0;
        end else begin
            char_prev   <= char_clk;
            strobe_prev <= load_strobe;
            hcount      <= next_hcount;
            vline       <= next_vline;
            scan        <= next_scan;
            drow        <= next_drow;
            rows_left   <= next_rows_left;
            in_data     <= next_in_data;
            since_vs    <= next_since_vs;
            vs_left     <= next_vs_left;
            vs_pos      <= next_vs_pos;
            fld         <= next_fld;
        end
    end

    assign char_count = hcount;
    assign row_select = scan;
    assign data_row   = drow;
    assign field      = fld;
    assign vsync      = (vs_left != 2'h0);

    // sync and blank share one skew, cursor has its own
    vtc_skew_line #(.W(2)) u_sync_skew (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .sel  (sb_sel),
        .d    ({hsync_raw, blank_raw}),
        .q    ({hsync, blank})
    );

    vtc_skew_line #(.W(1)) u_cursor_skew (
        .clk  (clk),
        .rst  (rst),
        .tick (tick),
        .sel  (cur_sel),
        .d    (cursor_raw),
        .q    (cursor_video)
    );
endmodule // vtc_timing

// file: testbench/tb_vtc_timing.sv
/*
 self-checking bench for the video timing controller.
 assumes the design, package, header, prom model and checker are compiled first.
*/
`timescale 1ns/1ps
`include "vtc_defs.svh"
module tb_vtc_timing;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        char_clk = 1'b0;
    logic        tick_run = 1'b0;
    logic        load_strobe = 1'b0;
    logic [3:0]  cmd = 4'h0;
    logic [7:0]  host_data = 8'h00;
    logic        host_on = 1'b1;
    logic        prom_on = 1'b0;
    logic [7:0]  bus_in;
    logic [7:0]  bus_out;
    logic        oe_n;
    logic [7:0]  char_count;
    logic [3:0]  row_select;
    logic [5:0]  data_row;
    logic        field;
    logic        hsync;
    logic        vsync;
    logic        blank;
    logic        cursor_video;
    logic [31:0] lfsr = 32'h1c9f;
    logic [7:0]  rd;
    logic        rdo;
    logic [5:0]  first_row;
    logic        seen;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n_clk, n_vs, n_bl, n_hs, n_cv, max_cc;
    logic [7:0]  words_a [0:6] = '{8'h17, 8'h09, 8'h08, 8'h00, 8'h04, 8'h01, 8'h01};
    logic [7:0]  words_b [0:6] = '{8'h23, 8'h11, 8'h01, 8'h01, 8'h02, 8'h01, 8'h01};

    vtc_timing i_vtc_timing (.clk(clk), .rst(rst), .char_clk(char_clk), .load_strobe(load_strobe),
        .command_select_lines(cmd), .parallel_bus_lines_in(bus_in), .parallel_bus_lines_out(bus_out),
        .parallel_bus_lines_oe_n(oe_n), .char_count(char_count), .row_select(row_select),
        .data_row(data_row), .field(field), .hsync(hsync), .vsync(vsync), .blank(blank),
        .cursor_video(cursor_video));
    vtc_prom_model i_vtc_prom_model (.clk(clk), .prom_on(prom_on), .host_on(host_on),
        .host_data(host_data), .row_select(row_select), .dev_oe_n(oe_n), .dev_data(bus_out), .bus(bus_in));

    always #50 clk = ~clk;
    // one character tick every two clocks
    always @(negedge clk) char_clk <= tick_run ? ~char_clk : 1'b0;

    always @(posedge clk) begin
        cyc++;
        n_clk++;
        n_vs += vsync;
        n_bl += !blank;
        n_hs += hsync;
        n_cv += cursor_video;
        if (char_count > max_cc) max_cc = char_count;
        if (!blank && !seen) begin
            first_row = data_row;
            seen = 1'b1;
        end
        if (cyc == 95000) begin
            error_cnt++;
            results();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // single strobe for reads and writes; code held past the release
    task automatic bus_op(input logic [3:0] code, input logic [7:0] data);
        @(negedge clk);
        cmd = code;
        host_data = data;
        load_strobe = 1'b1;
        repeat (3) @(negedge clk);
        rd = bus_out;
        rdo = oe_n;
        load_strobe = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic start_chain();
        tick_run = 1'b0;
        bus_op(`VTC_CMD_START, 8'h00);
        tick_run = 1'b1;
    endtask

    task automatic frame(input int w0, input int x, input int act, input int lines, input int hsw, input int row0,
                         input int cur);
        @(posedge vsync);
        n_clk = 0;
        n_vs = 0;
        n_bl = 0;
        n_hs = 0;
        n_cv = 0;
        max_cc = 0;
        seen = 1'b0;
        @(posedge vsync);
        chk("frame clocks", (2 * x + 256) * (w0 + 1) * 2, n_clk);
        chk("vsync clocks", 3 * (w0 + 1) * 2, n_vs);
        chk("active clocks", act * lines * 2, n_bl);
        chk("hsync clocks", (2 * x + 256) * hsw * 2, n_hs);
        chk("cursor clocks", cur * 2, n_cv);
        chk("even field", 1'b0, field);
        chk("last slot", w0, max_cc);
        chk("first row", row0, first_row);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        tick_run = 1'b1;
        for (int k = 0; k < 7; k++) bus_op(4'(k), words_a[k]);
        start_chain();
        bus_op(`VTC_CMD_SCROLL, 8'h00);
        frame(8'h17, 0, 20, 4, 1, 1, 2);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            bus_op(`VTC_CMD_LD_ROW, lfsr[7:0]);
            bus_op(`VTC_CMD_LD_COL, lfsr[15:8]);
            bus_op(`VTC_CMD_RD_ROW, 8'h00);
            chk("row read", lfsr[7:0], rd);
            chk("row drive", 1'b0, rdo);
            bus_op(`VTC_CMD_RD_COL, 8'h00);
            chk("col read", lfsr[15:8], rd);
            chk("bus release", 1'b1, oe_n);
        end
        bus_op(`VTC_CMD_RESET, 8'h00);
        repeat (4) begin
            repeat (50) @(negedge clk);
            chk("held count", 8'h00, char_count);
        end
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        for (int k = 0; k < 7; k++) i_vtc_prom_model.words[k] = words_b[k];
        prom_on = 1'b1;
        host_on = 1'b0;
        bus_op(`VTC_CMD_CPU_LOAD, 8'h00);
        // prom kept on well past seven lines of row select
        repeat (1000) @(negedge clk);
        prom_on = 1'b0;
        host_on = 1'b1;
        start_chain();
        repeat (3) bus_op(`VTC_CMD_SCROLL, 8'h00);
        frame(8'h23, 1, 32, 2, 2, 1, 1);
        // pin load: 1111 held past the strobe fall, then dropped with the character clock low
        prom_on = 1'b1;
        host_on = 1'b0;
        bus_op(`VTC_CMD_PIN_LOAD, 8'h00);
        repeat (1200) @(negedge clk);
        chk("load vsync", 1'b0, vsync);
        tick_run = 1'b0;
        @(negedge clk);
        cmd = 4'h0;
        prom_on = 1'b0;
        host_on = 1'b1;
        @(negedge clk);
        tick_run = 1'b1;
        // chain restarts within one line, so sync must be up well inside its three lines
        repeat (100) @(negedge clk);
        chk("load restart", 1'b1, vsync);
        results();
    end
endmodule // tb_vtc_timing

bind vtc_timing vtc_timing_properties i_vtc_timing_properties (.clk(clk), .rst(rst), .load_strobe(load_strobe),
    .command_select_lines(command_select_lines), .parallel_bus_lines_in(parallel_bus_lines_in),
    .parallel_bus_lines_out(parallel_bus_lines_out), .parallel_bus_lines_oe_n(parallel_bus_lines_oe_n),
    .char_count(char_count), .hsync(hsync), .vsync(vsync), .cursor_video(cursor_video));

// file: testbench/vtc_prom_model.sv
/*
 self load prom and data line resolution for the timing controller.
 assumes the bench fills words before prom_on rises.
*/
`timescale 1ns/1ps
module vtc_prom_model (
    input  wire logic       clk,
    input  wire logic       prom_on,
    input  wire logic       host_on,
    input  wire logic [7:0] host_data,
    input  wire logic [3:0] row_select,
    input  wire logic       dev_oe_n,
    input  wire logic [7:0] dev_data,
    output logic      [7:0] bus
);
    logic [7:0] words [0:15];
    logic [7:0] last;

    always_comb begin
        if (!dev_oe_n) bus = dev_data;
        else if (prom_on) bus = words[row_select];
        else if (host_on) bus = host_data;
        else bus = ~last; // released lines: no stale value
    end

    always_ff @(posedge clk) last <= bus;
endmodule // vtc_prom_model

// file: testbench/vtc_timing_properties.sv
/*
 port checker for the video timing controller.
 assumes it is bound onto vtc_timing with every port wired by name.
*/
`timescale 1ns/1ps
`include "vtc_defs.svh"
module vtc_timing_properties (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       load_strobe,
    input wire logic [3:0] command_select_lines,
    input wire logic [7:0] parallel_bus_lines_in,
    input wire logic [7:0] parallel_bus_lines_out,
    input wire logic       parallel_bus_lines_oe_n,
    input wire logic [7:0] char_count,
    input wire logic       hsync,
    input wire logic       vsync,
    input wire logic       cursor_video
);
    logic       strobe_d;
    logic       taken;
    logic [7:0] row_sh;
    logic [7:0] col_sh;
    logic [7:0] next_row_sh;
    logic [7:0] next_col_sh;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    assign taken = load_strobe && !strobe_d;

    // shadow cursor copies; loads only, reads never alter them
    always_comb begin
        next_row_sh = row_sh;
        next_col_sh = col_sh;
        if (taken && command_select_lines == `VTC_CMD_LD_ROW) next_row_sh = parallel_bus_lines_in;
        if (taken && command_select_lines == `VTC_CMD_LD_COL) next_col_sh = parallel_bus_lines_in;
    end

    always_ff @(posedge clk) begin
        strobe_d <= load_strobe & ~rst;
        row_sh   <= rst ? 8'h00 : next_row_sh;
        col_sh   <= rst ? 8'h00 : next_col_sh;
    end

    a_read_drive: assert property (
        taken && command_select_lines[3:1] == 3'b100 |-> ##[1:2] !parallel_bus_lines_oe_n)
        else $error("bus not driven for a cursor read");
    a_oe_release: assert property (
        !load_strobe && !strobe_d |-> parallel_bus_lines_oe_n)
        else $error("bus still driven after strobe low");
    a_oe_cause: assert property (
        !parallel_bus_lines_oe_n |-> $past(command_select_lines[3:1]) == 3'b100)
        else $error("bus driven without a read code");
    a_read_row: assert property (
        !parallel_bus_lines_oe_n && $past(parallel_bus_lines_oe_n) == 1'b0
        && command_select_lines == `VTC_CMD_RD_ROW |-> parallel_bus_lines_out == row_sh)
        else $error("cursor line read wrong");
    a_read_col: assert property (
        !parallel_bus_lines_oe_n && $past(parallel_bus_lines_oe_n) == 1'b0
        && command_select_lines == `VTC_CMD_RD_COL |-> parallel_bus_lines_out == col_sh)
        else $error("cursor character read wrong");
    a_count_step: assert property (
        char_count != $past(char_count) |-> char_count == $past(char_count) + 8'h01 || char_count == 8'h00)
        else $error("character count skipped");
    a_reset_hold: assert property (
        taken && command_select_lines == `VTC_CMD_RESET |-> ##2 (char_count == 8'h00) [*4])
        else $error("chain not held after reset command");
    a_rst_quiet: assert property (
        $past(rst) |-> parallel_bus_lines_oe_n && !hsync && !vsync && !cursor_video)
        else $error("outputs active out of reset");
endmodule // vtc_timing_properties
